// ---- core/amsq_defs.vh ----
// constants for the converter mode and calibration sequencer
`ifndef AMSQ_DEFS_VH
`define AMSQ_DEFS_VH
// ==========================================================
// register addresses on the special-function bus
`define AMSQ_ADDR_MODE 8'hd1
`define AMSQ_ADDR_STATUS 8'hd8
`define AMSQ_ADDR_RANGE 8'hd2
`define AMSQ_ADDR_CHREF 8'he6
`define AMSQ_ADDR_AUXCTL 8'he1
`define AMSQ_ADDR_AUXCFG1 8'he2
`define AMSQ_ADDR_AUXCFG2 8'he3
`define AMSQ_ADDR_FILTER 8'he4
`define AMSQ_ADDR_CHOP 8'he5
// ==========================================================
// reset values
`define AMSQ_RST_MODE 8'h00
`define AMSQ_RST_RANGE 8'h07
`define AMSQ_RST_CHREF 8'h00
`define AMSQ_RST_AUXCTL 8'h00
`define AMSQ_RST_FILTER 8'h45
// ==========================================================
// field positions
`define AMSQ_MODE_LSB 0
`define AMSQ_MODE_MSB 2
`define AMSQ_MODE_EN1_BIT 4
`define AMSQ_MODE_EN0_BIT 5
`define AMSQ_STAT_PRIMARY_RESULT_READY_BIT 7
`define AMSQ_STAT_AUXILIARY_RESULT_READY_BIT 6
`define AMSQ_STAT_AUXILIARY_ERROR_FLAG_BIT 4
`define AMSQ_AUXCH_LSB 4
`define AMSQ_AUXCH_MSB 7
`define AMSQ_AUX_TEMP_CODE 4'h8
// ==========================================================
// mode codes
`define AMSQ_MD_PDOWN 3'h0
`define AMSQ_MD_IDLE 3'h1
`define AMSQ_MD_SINGLE 3'h2
`define AMSQ_MD_CONT 3'h3
`define AMSQ_MD_IZS 3'h4
`define AMSQ_MD_IFS 3'h5
`define AMSQ_MD_SZS 3'h6
`define AMSQ_MD_SFS 3'h7
// ==========================================================
// timing: output periods per calibration, alignment limit
`define AMSQ_CAL_PER_CHOP 3'h2
`define AMSQ_CAL_PER_NOCHOP 3'h4
`define AMSQ_ALIGN_MAX 2'h3
`endif

// ---- core/amsq_period_timer.v ----
// output-period tick generator for one converter
`default_nettype none
module amsq_period_timer #(
   parameter WIDTH = 16
) (
   input wire clk,
   input wire reset,
   input wire restart,
   input wire run,
   input wire [WIDTH-1:0] period,
   output reg tick
);
   // ==========================================================
   // period counter
   reg [WIDTH-1:0] count; // cycles left in present period
   // counts down from period, ticks on reaching one
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else if (restart || !run) begin
         count <= period;
         tick <= 1'b0;
      end else if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
         count <= period;
         tick <= 1'b1;
      end else begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- core/amsq_sequencer.v ----
// converter mode, calibration and reset sequencer
//
// Summary of operation
// [RQ1] continuous mode refreshes results each output period
// [RQ2] internal zero calibration shorts inputs, offset cal
// [RQ3] internal full calibration uses selected reference
// [RQ4] system zero calibration uses selected channel inputs
// [RQ5] system full calibration uses selected channel inputs
// [RQ6] any mode write resets both converters; one that only raises the aux enable resets aux only
// [RQ7] aux config write with primary on resets both
// [RQ8] aux control write resets only auxiliary
// [RQ9] aux aligns to primary, up to three periods
// [RQ10] aux starts at once if primary finished
// [RQ11] power-down keeps mode, restarts on resume
// [RQ12] calibration write clears ready flags
// [RQ13] calibration end updates, mode returns to zero
// [RQ14] aux temperature-sensor calibration sets error flag
// [RQ15] calibration lasts two or four output periods
// [RQ16] software should calibrate at slowest filter rate
// [RQ17] mode field resets to power-down
// [RQ18] idle holds filter and modulator in reset
// [RQ19] single conversion ends in power-down
`default_nettype none
`include "amsq_defs.vh"
module amsq_sequencer #(
   parameter PER_WIDTH = 16,
   parameter CYC_PER_RATE = 8
) (
   input wire clk,
   input wire reset,
   input wire sfr_wr,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_rd,
   output reg [7:0] sfr_rdata,
   input wire chip_powerdown_bit,
   output reg primary_reset,
   output reg auxiliary_reset,
   output reg primary_run,
   output reg auxiliary_run,
   output reg modulator_hold,
   output reg primary_result_load,
   output reg auxiliary_result_load,
   output reg cal_short_inputs,
   output reg cal_use_reference,
   output reg cal_use_channel,
   output reg cal_gain,
   output reg primary_cal_load,
   output reg auxiliary_cal_load
);
   // ==========================================================
   // registers
   reg [7:0] converter_mode_register; // mode, enables
   reg [7:0] primary_range_control; // range, coding
   reg [7:0] primary_channel_reference_control; // ref, channel
   reg [7:0] auxiliary_control_register; // aux channel, ref
   reg [7:0] auxiliary_config_one; // aux config
   reg [7:0] auxiliary_config_two; // aux config
   reg [7:0] filter_rate_word; // output period scale
   reg chop_enable; // chopping on
   reg primary_result_ready; // status flags
   reg auxiliary_result_ready;
   reg auxiliary_error_flag;
   // ==========================================================
   // decoded views
   wire [2:0] converter_mode_field =
      converter_mode_register[`AMSQ_MODE_MSB:`AMSQ_MODE_LSB];
   wire primary_converter_enable =
      converter_mode_register[`AMSQ_MODE_EN0_BIT];
   wire auxiliary_converter_enable =
      converter_mode_register[`AMSQ_MODE_EN1_BIT];
   // top mode bit set means one of the four calibrations
   wire is_cal = converter_mode_field[2];
   wire active = !chip_powerdown_bit &&
      (converter_mode_field != `AMSQ_MD_PDOWN) &&
      (converter_mode_field != `AMSQ_MD_IDLE);
   wire aux_temp = auxiliary_control_register
      [`AMSQ_AUXCH_MSB:`AMSQ_AUXCH_LSB] == `AMSQ_AUX_TEMP_CODE;
   // output period in clocks; the product is cut to the timer width
   localparam integer RATE_SCALE = CYC_PER_RATE; // clocks per rate step
   wire [31:0] period_full = filter_rate_word * RATE_SCALE;
   wire [PER_WIDTH-1:0] period = period_full[PER_WIDTH-1:0];
   // one clock short: the aux reload lands a clock after the primary's
   wire [PER_WIDTH-1:0] period_less = period - {{(PER_WIDTH-1){1'b0}}, 1'b1};
   // ==========================================================
   // write decode
   wire wr_mode = sfr_wr && sfr_addr == `AMSQ_ADDR_MODE;
   wire wr_auxctl = sfr_wr && sfr_addr == `AMSQ_ADDR_AUXCTL;
   wire wr_auxcfg = sfr_wr && (sfr_addr == `AMSQ_ADDR_AUXCFG1 ||
      sfr_addr == `AMSQ_ADDR_AUXCFG2);
   wire en0_rise = wr_mode && !primary_converter_enable &&
      sfr_wdata[`AMSQ_MODE_EN0_BIT];
   wire en1_rise = wr_mode && !auxiliary_converter_enable &&
      sfr_wdata[`AMSQ_MODE_EN1_BIT];
   // a mode write that only raises the aux enable resets aux only
   wire mode_aux_only = en1_rise && !en0_rise &&
      sfr_wdata[2:0] == converter_mode_field &&
      sfr_wdata[`AMSQ_MODE_EN0_BIT] == primary_converter_enable;
   // primary changes always win: both converters restart
   wire both_reset = (wr_mode && !mode_aux_only) || // [RQ6]
      (wr_auxcfg && primary_converter_enable) || en0_rise; // [RQ7]
   wire aux_reset = both_reset || wr_auxctl || mode_aux_only; // [RQ8]
   // ==========================================================
   // power-down resume detect
   reg pd_prev; // last power-down level
   always @(posedge clk or posedge reset) begin
      if (reset)
         pd_prev <= 1'b0;
      else
         pd_prev <= chip_powerdown_bit;
   end
   // leaving power-down restarts whatever the mode selects
   wire resume = pd_prev && !chip_powerdown_bit; // [RQ11]
   // ==========================================================
   // period timers, primary and auxiliary
   wire p_tick;
   wire a_tick;
   reg a_align; // aux waiting for primary cadence
   // primary restarts on any both-converter reset
   amsq_period_timer #(.WIDTH(PER_WIDTH)) u_ptimer (
      .clk(clk),
      .reset(reset),
      .restart(both_reset || resume),
      .run(active && primary_converter_enable),
      .period(period),
      .tick(p_tick)
   );
   // aux timer is held while waiting to fall into step
   amsq_period_timer #(.WIDTH(PER_WIDTH)) u_atimer (
      .clk(clk),
      .reset(reset),
      .restart(aux_reset || resume || (a_align && p_tick)),
      .run(active && auxiliary_converter_enable && !a_align),
      // reload one short on release so both ticks land together
      .period(a_align ? period_less : period),
      .tick(a_tick)
   );
   // ==========================================================
   // calibration period counter
   reg [2:0] cal_cnt; // output periods elapsed
   wire cal_tick = primary_converter_enable ? p_tick : a_tick;
   wire [2:0] cal_need = chop_enable ? `AMSQ_CAL_PER_CHOP :
      `AMSQ_CAL_PER_NOCHOP; // [RQ15]
   // completes on the last needed output period tick
   wire cal_done = is_cal && active && cal_tick &&
      cal_cnt == cal_need - 3'h1;
   // ==========================================================
   // main sequencer
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         converter_mode_register <= `AMSQ_RST_MODE; // [RQ17]
         primary_range_control <= `AMSQ_RST_RANGE;
         primary_channel_reference_control <= `AMSQ_RST_CHREF;
         auxiliary_control_register <= `AMSQ_RST_AUXCTL;
         auxiliary_config_one <= 8'h00;
         auxiliary_config_two <= 8'h00;
         filter_rate_word <= `AMSQ_RST_FILTER;
         chop_enable <= 1'b1;
         primary_result_ready <= 1'b0;
         auxiliary_result_ready <= 1'b0;
         auxiliary_error_flag <= 1'b0;
         cal_cnt <= 3'h0;
         a_align <= 1'b0;
         primary_result_load <= 1'b0;
         auxiliary_result_load <= 1'b0;
         primary_cal_load <= 1'b0;
         auxiliary_cal_load <= 1'b0;
      end else begin
         primary_result_load <= 1'b0;
         auxiliary_result_load <= 1'b0;
         primary_cal_load <= 1'b0;
         auxiliary_cal_load <= 1'b0;
         // conversion results, continuous and single
         if (active && !is_cal) begin
            if (p_tick && primary_converter_enable) begin
               primary_result_load <= 1'b1; // [RQ1]
               primary_result_ready <= 1'b1;
            end
            if (a_tick && auxiliary_converter_enable) begin
               auxiliary_result_load <= 1'b1; // [RQ1]
               auxiliary_result_ready <= 1'b1;
            end
            // single: done on the primary result, or on the aux result when primary is off
            if (converter_mode_field == `AMSQ_MD_SINGLE &&
                  (primary_converter_enable ? p_tick : a_tick))
               converter_mode_register[2:0] <= `AMSQ_MD_PDOWN; // [RQ19]
         end
         // calibration period count and completion
         // count output periods while calibrating
         if (is_cal && active && cal_tick)
            cal_cnt <= cal_cnt + 3'h1;
         if (cal_done) begin
            cal_cnt <= 3'h0;
            converter_mode_register[2:0] <= `AMSQ_MD_PDOWN; // [RQ13]
            if (primary_converter_enable) begin
               primary_cal_load <= 1'b1;
               primary_result_ready <= 1'b1;
            end
            if (auxiliary_converter_enable) begin
               auxiliary_result_ready <= 1'b1; // [RQ14]
               // temperature input: flag error, keep old coefficients
               if (aux_temp)
                  auxiliary_error_flag <= 1'b1; // [RQ14]
               else
                  auxiliary_cal_load <= 1'b1;
            end
         end
         // alignment: aux released on the next primary output, which
         // keeps its first result well inside three primary periods
         if (a_align && p_tick)
            a_align <= 1'b0; // [RQ9]
         // register writes; resets restart counts
         if (both_reset)
            cal_cnt <= 3'h0;
         if (aux_reset && !both_reset) begin
            // wait only while primary is still converting
            a_align <= active && primary_converter_enable; // [RQ9]
            if (!(active && primary_converter_enable))
               a_align <= 1'b0; // [RQ10]
         end else if (both_reset)
            a_align <= 1'b0;
         // a written mode wins over a completion in the same clock
         if (wr_mode) begin
            converter_mode_register <= sfr_wdata;
            if (sfr_wdata[2]) begin
               primary_result_ready <= 1'b0; // [RQ12]
               auxiliary_result_ready <= 1'b0; // [RQ12]
               auxiliary_error_flag <= 1'b0;
            end
         end
         if (sfr_wr && sfr_addr == `AMSQ_ADDR_RANGE)
            primary_range_control <= sfr_wdata;
         if (sfr_wr && sfr_addr == `AMSQ_ADDR_CHREF)
            primary_channel_reference_control <= sfr_wdata;
         if (wr_auxctl)
            auxiliary_control_register <= sfr_wdata;
         if (sfr_wr && sfr_addr == `AMSQ_ADDR_AUXCFG1)
            auxiliary_config_one <= sfr_wdata;
         if (sfr_wr && sfr_addr == `AMSQ_ADDR_AUXCFG2)
            auxiliary_config_two <= sfr_wdata;
         if (sfr_wr && sfr_addr == `AMSQ_ADDR_FILTER)
            filter_rate_word <= sfr_wdata;
         if (sfr_wr && sfr_addr == `AMSQ_ADDR_CHOP)
            chop_enable <= sfr_wdata[0];
      end
   end
   // ==========================================================
   // converter control outputs
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         primary_reset <= 1'b1;
         auxiliary_reset <= 1'b1;
         primary_run <= 1'b0;
         auxiliary_run <= 1'b0;
         modulator_hold <= 1'b0;
         cal_short_inputs <= 1'b0;
         cal_use_reference <= 1'b0;
         cal_use_channel <= 1'b0;
         cal_gain <= 1'b0;
      end else begin
         // reset pulses last one clock after the causing write
         primary_reset <= both_reset || resume; // [RQ6]
         auxiliary_reset <= aux_reset || resume; // [RQ8]
         primary_run <= active && primary_converter_enable; // [RQ11]
         auxiliary_run <= active && auxiliary_converter_enable &&
            !a_align;
         // idle: clocks run, filter and modulator held
         modulator_hold <= !chip_powerdown_bit &&
            converter_mode_field == `AMSQ_MD_IDLE; // [RQ18]
         cal_short_inputs <= active &&
            converter_mode_field == `AMSQ_MD_IZS; // [RQ2]
         cal_use_reference <= active &&
            converter_mode_field == `AMSQ_MD_IFS; // [RQ3]
         cal_use_channel <= active && (converter_mode_field ==
            `AMSQ_MD_SZS || converter_mode_field ==
            `AMSQ_MD_SFS); // [RQ4] [RQ5]
         cal_gain <= active && is_cal && converter_mode_field[0];
      end
   end
   // ==========================================================
   // register read port
   // unmapped addresses read as zero
   always @(posedge clk or posedge reset) begin
      if (reset)
         sfr_rdata <= 8'h00;
      else if (sfr_rd) begin
         case (sfr_addr)
            `AMSQ_ADDR_MODE: sfr_rdata <= converter_mode_register;
            `AMSQ_ADDR_STATUS: sfr_rdata <= {primary_result_ready,
               auxiliary_result_ready, 1'b0, auxiliary_error_flag,
               4'h0};
            `AMSQ_ADDR_RANGE: sfr_rdata <= primary_range_control;
            `AMSQ_ADDR_CHREF:
               sfr_rdata <= primary_channel_reference_control;
            `AMSQ_ADDR_AUXCTL: sfr_rdata <= auxiliary_control_register;
            `AMSQ_ADDR_AUXCFG1: sfr_rdata <= auxiliary_config_one;
            `AMSQ_ADDR_AUXCFG2: sfr_rdata <= auxiliary_config_two;
            `AMSQ_ADDR_FILTER: sfr_rdata <= filter_rate_word;
            `AMSQ_ADDR_CHOP: sfr_rdata <= {7'h00, chop_enable};
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- testbench/amsq_monitor.sv ----
// port assertions for the mode and calibration sequencer
`default_nettype none
`include "amsq_defs.vh"
module amsq_monitor #(
   parameter PER_WIDTH = 16,
   parameter CYC_PER_RATE = 8
) (
   input wire clk,
   input wire reset,
   input wire sfr_wr,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire chip_powerdown_bit,
   input wire primary_reset,
   input wire auxiliary_reset,
   input wire primary_run,
   input wire auxiliary_run,
   input wire modulator_hold,
   input wire cal_short_inputs,
   input wire cal_use_reference,
   input wire cal_use_channel,
   input wire cal_gain
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // helper: mode writes and the primary enable last written
   wire mode_wr = sfr_wr && sfr_addr == `AMSQ_ADDR_MODE && !chip_powerdown_bit;
   wire cal_wr = mode_wr && sfr_wdata[5];
   reg en0_seen;
   // shadow of the primary enable
   always @(posedge clk or posedge reset) begin
      if (reset)
         en0_seen <= 1'b0;
      else if (mode_wr)
         en0_seen <= sfr_wdata[5];
   end
   // ==========================================================
   // assertions
   mode_reset_a: assert property (
      mode_wr && !sfr_wdata[4] |=> primary_reset && auxiliary_reset)
      else $error("mode write did not reset both converters");
   auxctl_only_a: assert property (
      sfr_wr && sfr_addr == `AMSQ_ADDR_AUXCTL && !chip_powerdown_bit
      |=> auxiliary_reset && !primary_reset)
      else $error("aux control write reset the wrong converters");
   auxcfg_both_a: assert property (
      sfr_wr && en0_seen && !chip_powerdown_bit &&
      (sfr_addr == `AMSQ_ADDR_AUXCFG1 || sfr_addr == `AMSQ_ADDR_AUXCFG2)
      |=> primary_reset && auxiliary_reset)
      else $error("aux config write did not reset both");
   reset_quiet_a: assert property (
      $fell(reset) |-> !primary_run && !auxiliary_run && !modulator_hold)
      else $error("converter active right after reset");
   zero_cal_a: assert property (
      cal_wr && sfr_wdata[2:0] == `AMSQ_MD_IZS
      |-> ##[1:2] cal_short_inputs && !cal_gain)
      else $error("internal zero calibration not shorting inputs");
   full_cal_a: assert property (
      cal_wr && sfr_wdata[2:0] == `AMSQ_MD_IFS
      |-> ##[1:2] cal_use_reference && cal_gain)
      else $error("internal full calibration not using reference");
   system_cal_a: assert property (
      cal_wr && sfr_wdata[2:1] == 2'b11 |-> ##[1:2] cal_use_channel)
      else $error("system calibration not using channel inputs");
   idle_hold_a: assert property (
      mode_wr && sfr_wdata[2:0] == `AMSQ_MD_IDLE |-> ##[1:2] modulator_hold)
      else $error("idle mode not holding modulator");
endmodule
bind amsq_sequencer amsq_monitor #(.PER_WIDTH(PER_WIDTH),
   .CYC_PER_RATE(CYC_PER_RATE)) u_amsq_monitor (.clk(clk), .reset(reset),
   .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
   .chip_powerdown_bit(chip_powerdown_bit), .primary_reset(primary_reset),
   .auxiliary_reset(auxiliary_reset), .primary_run(primary_run),
   .auxiliary_run(auxiliary_run), .modulator_hold(modulator_hold),
   .cal_short_inputs(cal_short_inputs), .cal_use_reference(cal_use_reference),
   .cal_use_channel(cal_use_channel), .cal_gain(cal_gain));
`default_nettype wire

// ---- testbench/tb_amsq_sequencer.sv ----
// self-checking bench for the mode and calibration sequencer
`default_nettype none
`include "amsq_defs.vh"
module tb_amsq_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {bit w; logic [7:0] a, d, e;} amsq_row_t;
   // ==========================================================
   // stimulus and observed signals
   logic clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, chip_powerdown_bit = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v;
   wire [7:0] sfr_rdata;
   wire primary_reset, auxiliary_reset, primary_run, auxiliary_run;
   wire modulator_hold, primary_result_load, auxiliary_result_load;
   wire cal_short_inputs, cal_use_reference, cal_use_channel, cal_gain;
   wire primary_cal_load, auxiliary_cal_load;
   wire [2:0] evt = {auxiliary_result_load, primary_result_load,
      primary_cal_load};
   int failures = 0, samples_checked = 0, n, i;
   amsq_row_t rows [8];
   // period is 2 * 4 = 8 cycles with filter word 2
   amsq_sequencer #(.PER_WIDTH(16), .CYC_PER_RATE(4)) u_amsq_sequencer (
      .clk(clk), .reset(reset), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .chip_powerdown_bit(chip_powerdown_bit), .primary_reset(primary_reset),
      .auxiliary_reset(auxiliary_reset), .primary_run(primary_run),
      .auxiliary_run(auxiliary_run), .modulator_hold(modulator_hold),
      .primary_result_load(primary_result_load),
      .auxiliary_result_load(auxiliary_result_load),
      .cal_short_inputs(cal_short_inputs),
      .cal_use_reference(cal_use_reference),
      .cal_use_channel(cal_use_channel), .cal_gain(cal_gain),
      .primary_cal_load(primary_cal_load),
      .auxiliary_cal_load(auxiliary_cal_load));
   // 100 ns clock
   always #50 clk = ~clk;
   // ==========================================================
   // shared tasks
   task check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 v = sfr_rdata;
   endtask
   // counts cycles until the chosen event pulse, bounded
   task waitev(input int s);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (evt[s] !== 1'b1 && n < 5000);
   endtask
   task summarize;
      $display("checked %0d, failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #1000000;
      failures++;
      summarize;
   end
   // ==========================================================
   // main sequence
   initial begin
      rows[0] = '{0, `AMSQ_ADDR_RANGE, 8'h00, `AMSQ_RST_RANGE};
      rows[1] = '{0, `AMSQ_ADDR_FILTER, 8'h00, `AMSQ_RST_FILTER};
      rows[2] = '{0, `AMSQ_ADDR_CHREF, 8'h00, `AMSQ_RST_CHREF};
      rows[3] = '{0, `AMSQ_ADDR_AUXCTL, 8'h00, `AMSQ_RST_AUXCTL};
      rows[4] = '{0, `AMSQ_ADDR_MODE, 8'h00, 8'h00};
      rows[5] = '{1, 8'h90, 8'ha5, 8'h00};
      rows[6] = '{1, `AMSQ_ADDR_RANGE, 8'h5a, 8'h5a};
      rows[7] = '{1, `AMSQ_ADDR_FILTER, 8'h02, 8'h02};
      repeat (2) @(posedge clk);
      #1 check(primary_reset, 1);
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[k]) begin
         if (rows[k].w)
            wr(rows[k].a, rows[k].d);
         rd(rows[k].a);
         check(v, rows[k].e);
      end
      $display("test registers finished");
      // continuous: one primary result per period
      wr(`AMSQ_ADDR_MODE, 8'h33);
      waitev(1);
      waitev(1);
      check(8'(n), 8'h08);
      // aux-only reset falls into the primary cadence
      wr(`AMSQ_ADDR_AUXCTL, 8'h10);
      waitev(2);
      check(n <= 24, 1);
      check(primary_result_load, 1);
      check(primary_run, 1);
      wr(`AMSQ_ADDR_AUXCFG1, 8'h00);
      $display("test continuous finished");
      // power-down keeps the mode and resumes it
      @(posedge clk) chip_powerdown_bit <= 1'b1;
      repeat (5) @(posedge clk);
      chip_powerdown_bit <= 1'b0;
      waitev(1);
      check(n < 40, 1);
      rd(`AMSQ_ADDR_MODE);
      check(v, 8'h33);
      // single conversion ends in power-down
      wr(`AMSQ_ADDR_MODE, 8'h22);
      waitev(1);
      repeat (2) @(posedge clk);
      rd(`AMSQ_ADDR_MODE);
      check(v, 8'h20);
      $display("test single finished");
      // every calibration code, chop on for the two internal codes, off for the two system codes
      for (i = 4; i < 8; i++) begin
         wr(`AMSQ_ADDR_CHOP, {7'h00, i < 6});
         wr(`AMSQ_ADDR_MODE, 8'(8'h20 | i));
         rd(`AMSQ_ADDR_STATUS);
         check(v[7], 0);
         waitev(0);
         check(8'((n + 6) / 8), i < 6 ? 8'h02 : 8'h04);
         repeat (2) @(posedge clk);
         rd(`AMSQ_ADDR_MODE);
         check(v, 8'h20);
         rd(`AMSQ_ADDR_STATUS);
         check(v[7], 1);
      end
      $display("test calibration finished");
      // idle holds the modulator
      wr(`AMSQ_ADDR_MODE, 8'h21);
      repeat (2) @(posedge clk);
      #1 check(modulator_hold, 1);
      check(primary_run, 0);
      // aux calibration on the temperature sensor fails
      wr(`AMSQ_ADDR_AUXCTL, 8'h80);
      wr(`AMSQ_ADDR_MODE, 8'h14);
      n = 0;
      repeat (60) begin
         @(posedge clk);
         #1 if (auxiliary_cal_load === 1'b1) n++;
      end
      check(8'(n), 8'h00);
      rd(`AMSQ_ADDR_STATUS);
      check(v & 8'h50, 8'h50);
      $display("test aux fault finished");
      // aux restart with the primary off starts at once
      wr(`AMSQ_ADDR_MODE, 8'h13);
      wr(`AMSQ_ADDR_AUXCTL, 8'h10);
      waitev(2);
      check(8'(n), 8'h09);
      $display("test aux start finished");
      // reset again in mid-run: registers back to defaults
      @(posedge clk) reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(`AMSQ_ADDR_MODE);
      check(v, `AMSQ_RST_MODE);
      check(auxiliary_run, 0);
      rd(`AMSQ_ADDR_FILTER);
      check(v, `AMSQ_RST_FILTER);
      $display("test mid-run reset finished");
      // calibration at the slowest rate, 255 * 4 clocks a period
      wr(`AMSQ_ADDR_FILTER, 8'hff);
      wr(`AMSQ_ADDR_MODE, 8'h24);
      waitev(0);
      check(8'(n / 1020), 8'h02);
      $display("test slow calibration finished");
      summarize;
   end
endmodule
`default_nettype wire
